// file: rtl/csw_mode_ctrl.sv
// Transceiver mode control with selective wake, register port and interrupt.
// Assumes frame decoder events arrive as one-cycle pulses on clock_in; the bus
// receive pin and the transmit data pin are asynchronous and are synchronised here.
//
// How it works
// - Mode field accepts writes only while the power mode is Normal.
// - Field 000/100 off, 001 wake, 010 rx only, 011 normal, 1xx with selective wake.
// - Normal with selective wake transmits, receives and runs the frame detector.
// - Frame wake in normal-with-selective-wake raises interrupt, receive output not pulled low.
// - Receive only with selective wake passes bus data, never drives the bus.
// - Error flag set means a config valid check failed or the counter overflowed.
// - Mode field reads back as programmed; status shows error, armed and woken state.
// - Leaving Normal may rewrite the two low field bits per target power mode.
// - Stop keeps the field; error flag makes 1xx modes run without selective wake.
// - Error flag blocks frame detection but leaves the field top bit unchanged.
// - Sleep maps 010/011 to 001, 110/111 to 101, off stays off.
// - Frame wake in Sleep enters Restart, clears config valid, reports 101.
// - Entering Sleep with a woken transceiver re-arms it automatically.
// - Enabling selective wake checks config valid and sets the error flag on failure.
// - Each setting of the error flag raises the interrupt unless masked.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "csw_params.svh"

module csw_mode_ctrl
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [`CSW_ADDR_W-1:0] addr_in,
   input wire logic [`CSW_DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [`CSW_DATA_W-1:0] rdata_out,
   input wire logic bus_rx_in,
   input wire logic tx_data_in,
   input wire logic wake_frame_in,
   input wire logic wake_pattern_in,
   input wire logic err_overflow_in,
   input wire logic silence_timeout_in,
   output logic rx_out,
   output logic bus_dominant_out,
   output logic detector_enable_out,
   output logic counter_clear_out,
   output logic bus_silence_flag_out,
   output logic interrupt_out_n
);
   csw_pkg::csw_state_s st_r;
   csw_pkg::csw_state_s st_nxt;
   csw_mode_if mif ();

   csw_mode_map u_map
   (
      .m(mif.map)
   );

   function automatic logic [1:0] pm_code(input csw_pkg::csw_pm_e pm);
      case (pm)
         csw_pkg::PM_NORMAL: pm_code = `CSW_PM_NORMAL;
         csw_pkg::PM_STOP: pm_code = `CSW_PM_STOP;
         csw_pkg::PM_SLEEP: pm_code = `CSW_PM_SLEEP;
         default: pm_code = `CSW_PM_RESTART;
      endcase
   endfunction

   function automatic logic is_swk_mode(input csw_pkg::csw_mode_t m);
      is_swk_mode = m[2] && (m[1:0] != `CSW_LOW_OFF);
   endfunction

   // Low field bits taken on entry to Sleep; off modes keep their value.
   function automatic csw_pkg::csw_mode_t sleep_map(input csw_pkg::csw_mode_t m);
      if (m[1:0] == `CSW_LOW_OFF)
      begin
         sleep_map = m;
      end
      else
      begin
         sleep_map = {m[2], `CSW_LOW_WK};
      end
   endfunction

   function automatic logic [`CSW_DATA_W-1:0] read_mux(input csw_pkg::csw_state_s s,
      input logic [`CSW_ADDR_W-1:0] a, input logic swk_run);
      logic [`CSW_DATA_W-1:0] d;
      d = '0;
      case (a)
         `CSW_OFS_CTRL:
         begin
            d[`CSW_CTRL_MODE_HI:`CSW_CTRL_MODE_LO] = s.mode;
            d[`CSW_CTRL_PM_HI:`CSW_CTRL_PM_LO] = pm_code(s.pm);
         end
         `CSW_OFS_CFG:
         begin
            d[`CSW_CFG_VALID_BIT] = s.cfg_valid;
            d[`CSW_CFG_ERR_BIT] = s.err;
         end
         `CSW_OFS_STAT:
         begin
            d[`CSW_STAT_SILENCE_BIT] = s.silence;
            d[`CSW_STAT_ERR_BIT] = s.err;
            d[`CSW_STAT_ARMED_BIT] = s.armed;
            d[`CSW_STAT_WOKEN_BIT] = s.woken;
            d[`CSW_STAT_SWK_RUN_BIT] = swk_run;
            d[`CSW_STAT_PM_HI:`CSW_STAT_PM_LO] = pm_code(s.pm);
         end
         `CSW_OFS_IRQ_STAT: d[`CSW_IRQ_W-1:0] = s.irq_stat;
         `CSW_OFS_IRQ_MASK: d[`CSW_IRQ_W-1:0] = s.irq_mask;
         default: d = '0;
      endcase
      read_mux = d;
   endfunction

   logic wr_ctrl;
   logic wr_cfg;
   logic [1:0] pm_req;
   csw_pkg::csw_mode_t wmode;
   logic err_set;
   logic err_clr;
   logic frame_wake;
   logic pattern_wake;
   logic [`CSW_IRQ_W-1:0] irq_set;
   logic in_normal;

   always_comb
   begin
      st_nxt = st_r;
      wr_ctrl = wr_in && (addr_in == `CSW_OFS_CTRL);
      wr_cfg = wr_in && (addr_in == `CSW_OFS_CFG);
      pm_req = wdata_in[`CSW_CTRL_PM_HI:`CSW_CTRL_PM_LO];
      wmode = wdata_in[`CSW_CTRL_MODE_HI:`CSW_CTRL_MODE_LO];
      in_normal = (st_r.pm == csw_pkg::PM_NORMAL);
      err_set = 1'b0;
      irq_set = '0;

      // Pin synchronisers: a change is taken once stages two and three agree.
      st_nxt.rx_sync = {st_r.rx_sync[1:0], bus_rx_in};
      st_nxt.tx_sync = {st_r.tx_sync[1:0], tx_data_in};
      if (st_r.rx_sync[1] == st_r.rx_sync[2])
      begin
         st_nxt.rx_filt = st_r.rx_sync[2];
      end
      if (st_r.tx_sync[1] == st_r.tx_sync[2])
      begin
         st_nxt.tx_filt = st_r.tx_sync[2];
      end

      // Wake events count only while the transceiver has not yet woken.
      frame_wake = wake_frame_in && mif.swk_run && !st_r.woken
         && (st_r.pm != csw_pkg::PM_RESTART);
      pattern_wake = wake_pattern_in && mif.wake_cap && !mif.swk_run && !st_r.woken;

      // Config valid write; a drop while selective wake runs in Normal is an error.
      if (wr_cfg && in_normal)
      begin
         st_nxt.cfg_valid = wdata_in[`CSW_CFG_VALID_BIT];
         if (!wdata_in[`CSW_CFG_VALID_BIT] && is_swk_mode(st_r.mode))
         begin
            err_set = 1'b1;
         end
      end

      // Mode field write, Normal only; a change of value re-arms a woken transceiver.
      if (wr_ctrl && in_normal)
      begin
         st_nxt.mode = wmode;
         if (wmode != st_r.mode)
         begin
            st_nxt.woken = 1'b0;
         end
         if (!wmode[2])
         begin
            st_nxt.armed = 1'b0;
         end
         if (is_swk_mode(wmode))
         begin
            if (st_nxt.cfg_valid)
            begin
               st_nxt.armed = 1'b1;
            end
            else
            begin
               err_set = 1'b1;
            end
         end
      end

      // Counter overflow disables selective wake and wakes the transceiver.
      if (err_overflow_in && mif.swk_run)
      begin
         err_set = 1'b1;
         st_nxt.woken = 1'b1;
      end

      if (frame_wake)
      begin
         st_nxt.woken = 1'b1;
         st_nxt.armed = 1'b0;
         if (st_r.pm == csw_pkg::PM_SLEEP)
         begin
            st_nxt.pm = csw_pkg::PM_RESTART;
            st_nxt.cfg_valid = 1'b0;
            st_nxt.mode = `CSW_MODE_SWK;
         end
         else
         begin
            irq_set[`CSW_IRQ_FRAME_BIT] = 1'b1;
         end
      end

      if (pattern_wake)
      begin
         st_nxt.woken = 1'b1;
         st_nxt.armed = 1'b0;
         st_nxt.silence = 1'b0;
         if (st_r.pm == csw_pkg::PM_SLEEP)
         begin
            st_nxt.pm = csw_pkg::PM_RESTART;
         end
         else
         begin
            irq_set[`CSW_IRQ_PATTERN_BIT] = 1'b1;
         end
      end

      // Bus silence flag from the running detector; set wins over a pattern clear.
      if (silence_timeout_in && mif.swk_run)
      begin
         st_nxt.silence = 1'b1;
         irq_set[`CSW_IRQ_SILENCE_BIT] = 1'b1;
      end

      // Error clear cannot succeed while a selective-wake mode lacks a valid config.
      err_clr = wr_cfg && wdata_in[`CSW_CFG_ERR_BIT]
         && !(st_r.mode[2] && !st_r.cfg_valid);
      if (err_clr)
      begin
         st_nxt.err = 1'b0;
      end
      if (err_set)
      begin
         st_nxt.err = 1'b1;
         st_nxt.armed = 1'b0;
         irq_set[`CSW_IRQ_ERR_BIT] = 1'b1;
      end

      // Power-mode commands; Sleep accepts none and leaves only on a wake.
      if (wr_ctrl)
      begin
         case (st_r.pm)
            csw_pkg::PM_NORMAL:
            begin
               if (pm_req == `CSW_PM_STOP)
               begin
                  st_nxt.pm = csw_pkg::PM_STOP;
               end
               else if (pm_req == `CSW_PM_SLEEP)
               begin
                  st_nxt.pm = csw_pkg::PM_SLEEP;
                  st_nxt.mode = sleep_map(st_nxt.mode);
                  st_nxt.woken = 1'b0;
                  st_nxt.armed = is_swk_mode(st_nxt.mode) && !st_nxt.err;
               end
               else
               begin
                  st_nxt.pm = st_r.pm;
               end
            end
            csw_pkg::PM_STOP, csw_pkg::PM_RESTART:
            begin
               if (pm_req == `CSW_PM_NORMAL)
               begin
                  st_nxt.pm = csw_pkg::PM_NORMAL;
               end
            end
            default: st_nxt.pm = st_r.pm;
         endcase
      end

      // Interrupt status: hardware set wins over a write-one clear.
      if (wr_in && (addr_in == `CSW_OFS_IRQ_STAT))
      begin
         st_nxt.irq_stat = st_r.irq_stat & ~wdata_in[`CSW_IRQ_W-1:0];
      end
      st_nxt.irq_stat = st_nxt.irq_stat | irq_set;
      if (wr_in && (addr_in == `CSW_OFS_IRQ_MASK))
      begin
         st_nxt.irq_mask = wdata_in[`CSW_IRQ_W-1:0];
      end

      // Read data stands for the single cycle after the strobe.
      st_nxt.rdata = rd_in ? read_mux(st_r, addr_in, mif.swk_run) : '0;

      // A woken, wake-capable transceiver pulls receive low; active modes pass bus data.
      if (mif.rx_en)
      begin
         st_nxt.rx_pin = st_r.rx_filt;
      end
      else
      begin
         st_nxt.rx_pin = !(st_r.woken && mif.wake_cap);
      end
      st_nxt.bus_dom = mif.tx_en && !st_r.tx_filt;
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         st_r.pm <= csw_pkg::PM_NORMAL;
         st_r.mode <= `CSW_MODE_OFF;
         st_r.err <= 1'b0;
         st_r.armed <= 1'b0;
         st_r.cfg_valid <= 1'b0;
         st_r.woken <= 1'b0;
         st_r.silence <= 1'b0;
         st_r.irq_stat <= '0;
         st_r.irq_mask <= `CSW_IRQ_MASK_RST;
         st_r.rdata <= '0;
         st_r.rx_sync <= '1;
         st_r.tx_sync <= '1;
         st_r.rx_filt <= 1'b1;
         st_r.tx_filt <= 1'b1;
         st_r.rx_pin <= 1'b1;
         st_r.bus_dom <= 1'b0;
      end
      else if (ce_in)
      begin
         st_r <= st_nxt;
      end
   end

   assign mif.mode = st_r.mode;
   assign mif.err = st_r.err;
   assign mif.pm = st_r.pm;

   assign rdata_out = st_r.rdata;
   assign rx_out = st_r.rx_pin;
   assign bus_dominant_out = st_r.bus_dom;
   assign detector_enable_out = mif.swk_run;
   // Counter held cleared in off modes and in plain wake-capable mode.
   assign counter_clear_out = (st_r.mode[1:0] == `CSW_LOW_OFF)
      || (st_r.mode == `CSW_MODE_WK);
   assign bus_silence_flag_out = st_r.silence;
   assign interrupt_out_n = ~|(st_r.irq_stat & st_r.irq_mask);
endmodule

// file: rtl/csw_mode_if.sv
// Carrier between the mode controller and the mode mapper.
// Assumes both ends sit in the same clock domain; the mapper is combinational.
interface csw_mode_if;
   csw_pkg::csw_mode_t mode;
   logic err;
   csw_pkg::csw_pm_e pm;
   logic rx_en;
   logic tx_en;
   logic wake_cap;
   logic swk_run;

   modport ctrl (output mode, output err, output pm,
      input rx_en, input tx_en, input wake_cap, input swk_run);
   modport map (input mode, input err, input pm,
      output rx_en, output tx_en, output wake_cap, output swk_run);
endinterface

// file: rtl/csw_mode_map.sv
// Maps mode field, error flag and power mode to the effective transceiver behaviour.
// Assumes the controller has already remapped the field on entry to Sleep.
`include "csw_params.svh"

module csw_mode_map
(
   csw_mode_if.map m
);
   logic [1:0] low;
   logic lowpower;

   always_comb
   begin
      low = m.mode[1:0];
      lowpower = (m.pm == csw_pkg::PM_SLEEP) || (m.pm == csw_pkg::PM_RESTART);
      // Error flag suppresses the frame detector but the field is left alone.
      m.swk_run = m.mode[2] && (low != `CSW_LOW_OFF) && !m.err;
      m.wake_cap = (low != `CSW_LOW_OFF) && (lowpower || (low == `CSW_LOW_WK));
      m.rx_en = !lowpower && (low[1] == 1'b1);
      m.tx_en = !lowpower && (low == `CSW_LOW_NORM);
   end
endmodule

// file: rtl/csw_params.svh
// Constants for the CAN selective-wake mode control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH

// Register byte offsets on the plain register port.
`define CSW_OFS_CTRL 8'h00
`define CSW_OFS_CFG 8'h04
`define CSW_OFS_STAT 8'h08
`define CSW_OFS_IRQ_STAT 8'h0C
`define CSW_OFS_IRQ_MASK 8'h10

// CTRL layout: transceiver mode field and power-mode command.
`define CSW_CTRL_MODE_HI 2
`define CSW_CTRL_MODE_LO 0
`define CSW_CTRL_PM_HI 5
`define CSW_CTRL_PM_LO 4

// CFG layout: configuration valid (read/write), error flag (write one to clear).
`define CSW_CFG_VALID_BIT 0
`define CSW_CFG_ERR_BIT 1

// STAT layout.
`define CSW_STAT_SILENCE_BIT 0
`define CSW_STAT_ERR_BIT 1
`define CSW_STAT_ARMED_BIT 2
`define CSW_STAT_WOKEN_BIT 3
`define CSW_STAT_SWK_RUN_BIT 4
`define CSW_STAT_PM_HI 9
`define CSW_STAT_PM_LO 8

// Interrupt status and mask bits.
`define CSW_IRQ_W 4
`define CSW_IRQ_FRAME_BIT 0
`define CSW_IRQ_PATTERN_BIT 1
`define CSW_IRQ_ERR_BIT 2
`define CSW_IRQ_SILENCE_BIT 3
`define CSW_IRQ_MASK_RST 4'h0

// Power-mode codes as seen in CTRL and STAT.
`define CSW_PM_NORMAL 2'h0
`define CSW_PM_STOP 2'h1
`define CSW_PM_SLEEP 2'h2
`define CSW_PM_RESTART 2'h3

// Transceiver mode field values.
`define CSW_MODE_OFF 3'h0
`define CSW_MODE_WK 3'h1
`define CSW_MODE_RXO 3'h2
`define CSW_MODE_NORM 3'h3
`define CSW_MODE_OFF_HI 3'h4
`define CSW_MODE_SWK 3'h5
`define CSW_MODE_RXO_SWK 3'h6
`define CSW_MODE_NORM_SWK 3'h7
`define CSW_LOW_OFF 2'h0
`define CSW_LOW_WK 2'h1
`define CSW_LOW_NORM 2'h3

`define CSW_DATA_W 32
`define CSW_ADDR_W 8
`define CSW_SYNC_W 3

`endif

// file: rtl/csw_pkg.sv
// Types shared by the mode control block and its mode mapper.
// Assumes csw_params.svh is on the include path.
`include "csw_params.svh"

package csw_pkg;

   typedef enum logic [1:0] {PM_NORMAL, PM_STOP, PM_SLEEP, PM_RESTART} csw_pm_e;

   typedef logic [2:0] csw_mode_t;

   typedef struct packed {
      csw_pm_e pm;
      csw_mode_t mode;
      logic err;
      logic armed;
      logic cfg_valid;
      logic woken;
      logic silence;
      logic [`CSW_IRQ_W-1:0] irq_stat;
      logic [`CSW_IRQ_W-1:0] irq_mask;
      logic [`CSW_DATA_W-1:0] rdata;
      logic [`CSW_SYNC_W-1:0] rx_sync;
      logic [`CSW_SYNC_W-1:0] tx_sync;
      logic rx_filt;
      logic tx_filt;
      logic rx_pin;
      logic bus_dom;
   } csw_state_s;

endpackage

// file: test/csw_bus_model.sv
// Model of the bus nodes and the frame decoder beside the controller.
// Assumes the testbench calls its tasks from the clock domain of clock_in.
module csw_bus_model
(
   input wire logic clock_in,
   input wire logic dut_dominant_in,
   output logic bus_rx_out,
   output logic [3:0] event_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic node_dominant;
   // Wired-AND bus: any dominant driver, the controller included, pulls it low.
   assign bus_rx_out = !(node_dominant || dut_dominant_in);
   initial
   begin
      node_dominant = 1'b0;
      event_out = 4'h0;
   end
   // Event order: frame, pattern, overflow, silence; each lasts one cycle.
   task automatic pulse(input int idx);
      @(posedge clock_in);
      event_out <= 4'h1 << idx;
      @(posedge clock_in);
      event_out <= 4'h0;
   endtask
   task automatic drive(input logic dom);
      @(posedge clock_in);
      node_dominant <= dom;
   endtask
endmodule

// file: test/csw_mode_ctrl_assertions.sv
// Port-level checker for the selective-wake mode controller.
// Assumes one clock domain and a synchronous active-low reset.
`include "csw_params.svh"

module csw_mode_ctrl_assertions
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [`CSW_DATA_W-1:0] rdata_out,
   input wire logic wake_frame_in,
   input wire logic wake_pattern_in,
   input wire logic err_overflow_in,
   input wire logic silence_timeout_in,
   input wire logic bus_dominant_out,
   input wire logic detector_enable_out,
   input wire logic counter_clear_out,
   input wire logic bus_silence_flag_out,
   input wire logic interrupt_out_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cause;
   // Only a register write or a decoder event may set a sticky interrupt bit.
   assign cause = wr_in | wake_frame_in | wake_pattern_in | err_overflow_in | silence_timeout_in;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   a_read_idle: assert property (!rd_in && ce_in |=> rdata_out == '0)
      else $error("Read data present outside the read cycle.");
   a_clear_no_drive: assert property (counter_clear_out [*3] |-> !bus_dominant_out)
      else $error("Bus driven while the transceiver is off or wake capable.");
   a_detect_exclusive: assert property (detector_enable_out |-> !counter_clear_out)
      else $error("Detector running while the counter is held clear.");
   a_irq_cause: assert property ($fell(interrupt_out_n) |-> $past(cause))
      else $error("Interrupt asserted without a cause.");
   a_irq_release: assert property ($rose(interrupt_out_n) |-> $past(wr_in))
      else $error("Interrupt released without a register write.");
   a_silence_set: assert property ($rose(bus_silence_flag_out)
      |-> $past(silence_timeout_in) && $past(detector_enable_out))
      else $error("Silence flag set without a counted timeout.");
   a_silence_clear: assert property ($fell(bus_silence_flag_out) |-> $past(wake_pattern_in))
      else $error("Silence flag cleared without a wake pattern.");
   // A frozen clock enable swallows the overflow pulse, so only a taken one counts.
   a_overflow_stop: assert property (ce_in && err_overflow_in && detector_enable_out
      |=> !detector_enable_out)
      else $error("Detector still running after counter overflow.");
   a_detect_rise: assert property ($rose(detector_enable_out) |-> $past(wr_in))
      else $error("Detector started without a register write.");

   c_irq: cover property ($fell(interrupt_out_n));
   c_overflow: cover property (err_overflow_in && detector_enable_out);
   c_silence: cover property ($rose(bus_silence_flag_out));
   c_drive: cover property (bus_dominant_out);
endmodule

bind csw_mode_ctrl csw_mode_ctrl_assertions csw_mode_ctrl_assertions_inst (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .wake_frame_in(wake_frame_in), .wake_pattern_in(wake_pattern_in),
   .err_overflow_in(err_overflow_in), .silence_timeout_in(silence_timeout_in),
   .bus_dominant_out(bus_dominant_out), .detector_enable_out(detector_enable_out),
   .counter_clear_out(counter_clear_out), .bus_silence_flag_out(bus_silence_flag_out),
   .interrupt_out_n(interrupt_out_n));

// file: test/tb.sv
// Self-checking testbench for the selective-wake mode controller.
// Assumes csw_params.svh on the include path and the bus model beside it.
`include "csw_params.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in;
   logic rst_n_in;
   logic ce_in;
   logic [7:0] addr_in;
   logic [31:0] wdata_in;
   logic wr_in;
   logic rd_in;
   logic tx_data_in;
   logic [31:0] rdata_out;
   logic [3:0] ev;
   logic bus_rx, rx_out, bus_dom, det_en, cnt_clr, sil, irq_n;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [2:0] progs [5] = '{3'h4, 3'h2, 3'h3, 3'h6, 3'h7};
   logic [2:0] maps [5] = '{3'h4, 3'h1, 3'h1, 3'h5, 3'h5};

   always #5 clock_in = !clock_in;

   csw_mode_ctrl csw_mode_ctrl_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .bus_rx_in(bus_rx), .tx_data_in(tx_data_in),
      .wake_frame_in(ev[0]), .wake_pattern_in(ev[1]), .err_overflow_in(ev[2]),
      .silence_timeout_in(ev[3]), .rx_out(rx_out), .bus_dominant_out(bus_dom),
      .detector_enable_out(det_en), .counter_clear_out(cnt_clr),
      .bus_silence_flag_out(sil), .interrupt_out_n(irq_n));
   csw_bus_model csw_bus_model_inst (.clock_in(clock_in), .dut_dominant_in(bus_dom),
      .bus_rx_out(bus_rx), .event_out(ev));

   task automatic summarize();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // A hang counts as a failure and still reaches the closing report.
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clock_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
   endtask
   task automatic do_reset();
      @(posedge clock_in);
      rst_n_in <= 1'b0;
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
   endtask
   task automatic wait_pins();
      repeat (8) @(posedge clock_in);
      #1;
   endtask

   task automatic s_reset_values();
      rchk(`CSW_OFS_CTRL, 32'h0);
      rchk(`CSW_OFS_STAT, 32'h0);
      rchk(`CSW_OFS_IRQ_MASK, 32'h0);
      rchk(8'h14, 32'h0);
      chk(32'(irq_n), 32'h1);
      chk(32'(cnt_clr), 32'h1);
   endtask
   task automatic s_mode_table();
      wr(`CSW_OFS_CFG, 32'h1);
      for (int m = 0; m < 8; m++)
      begin
         wr(`CSW_OFS_CTRL, 32'(m));
         rchk(`CSW_OFS_CTRL, 32'(m));
         chk(32'(cnt_clr), 32'(m == 0 || m == 1 || m == 4));
         chk(32'(det_en), 32'(m >= 5));
      end
      rchk(`CSW_OFS_STAT, 32'h14);
   endtask
   task automatic s_cfg_error();
      wr(`CSW_OFS_CTRL, 32'h0);
      wr(`CSW_OFS_CFG, 32'h0);
      wr(`CSW_OFS_IRQ_MASK, 32'h4);
      wr(`CSW_OFS_CTRL, 32'h7);
      chk(32'(irq_n), 32'h0);
      chk(32'(det_en), 32'h0);
      rchk(`CSW_OFS_CTRL, 32'h7);
      rchk(`CSW_OFS_CFG, 32'h2);
      wr(`CSW_OFS_CFG, 32'h2);
      rchk(`CSW_OFS_CFG, 32'h2);
      wr(`CSW_OFS_CFG, 32'h1);
      wr(`CSW_OFS_CFG, 32'h3);
      rchk(`CSW_OFS_CFG, 32'h1);
      wr(`CSW_OFS_IRQ_STAT, 32'h4);
      chk(32'(irq_n), 32'h1);
      wr(`CSW_OFS_CTRL, 32'h0);
      wr(`CSW_OFS_CTRL, 32'h7);
      chk(32'(det_en), 32'h1);
   endtask
   task automatic s_stop();
      wr(`CSW_OFS_CTRL, 32'h17);
      rchk(`CSW_OFS_CTRL, 32'h17);
      wr(`CSW_OFS_CTRL, 32'h12);
      rchk(`CSW_OFS_CTRL, 32'h17);
      chk(32'(det_en), 32'h1);
      csw_bus_model_inst.pulse(3);
      rchk(`CSW_OFS_STAT, 32'h115);
      chk(32'(sil), 32'h1);
      csw_bus_model_inst.pulse(2);
      rchk(`CSW_OFS_CTRL, 32'h17);
      rchk(`CSW_OFS_CFG, 32'h3);
      chk(32'(det_en), 32'h0);
      chk(32'(irq_n), 32'h0);
      wr(`CSW_OFS_IRQ_STAT, 32'hF);
      wr(`CSW_OFS_CTRL, 32'h07);
      rchk(`CSW_OFS_CTRL, 32'h07);
   endtask
   task automatic s_sleep_map();
      for (int i = 0; i < 5; i++)
      begin
         do_reset();
         wr(`CSW_OFS_CFG, 32'h1);
         wr(`CSW_OFS_CTRL, 32'(progs[i]));
         wr(`CSW_OFS_CTRL, 32'h20 | 32'(progs[i]));
         rchk(`CSW_OFS_CTRL, 32'h20 | 32'(maps[i]));
         chk(32'(det_en), 32'(maps[i] == 3'h5));
      end
      csw_bus_model_inst.pulse(0);
      rchk(`CSW_OFS_CTRL, 32'h35);
      rchk(`CSW_OFS_CFG, 32'h0);
      wr(`CSW_OFS_CTRL, 32'h0);
      wr(`CSW_OFS_CTRL, 32'h3);
      wr(`CSW_OFS_CFG, 32'h1);
      wr(`CSW_OFS_CFG, 32'h3);
      wr(`CSW_OFS_CTRL, 32'h5);
      wr(`CSW_OFS_CTRL, 32'h25);
      rchk(`CSW_OFS_STAT, 32'h214);
      csw_bus_model_inst.pulse(0);
      rchk(`CSW_OFS_CTRL, 32'h35);
      wr(`CSW_OFS_CTRL, 32'h0);
   endtask
   task automatic s_auto_rearm();
      do_reset();
      wr(`CSW_OFS_CFG, 32'h1);
      wr(`CSW_OFS_CTRL, 32'h7);
      wr(`CSW_OFS_IRQ_MASK, 32'h2);
      csw_bus_model_inst.pulse(3);
      csw_bus_model_inst.pulse(2);
      csw_bus_model_inst.pulse(1);
      chk(32'(irq_n), 32'h1);
      wr(`CSW_OFS_CTRL, 32'h27);
      rchk(`CSW_OFS_CTRL, 32'h25);
      csw_bus_model_inst.pulse(1);
      rchk(`CSW_OFS_CTRL, 32'h35);
      chk(32'(sil), 32'h0);
      wr(`CSW_OFS_CTRL, 32'h0);
   endtask
   task automatic s_pins();
      // The earlier overflow left the error flag set; clear it so frames count again.
      wr(`CSW_OFS_CFG, 32'h3);
      wr(`CSW_OFS_CTRL, 32'h6);
      @(posedge clock_in);
      tx_data_in <= 1'b0;
      csw_bus_model_inst.drive(1'b1);
      wait_pins();
      chk(32'(bus_dom), 32'h0);
      chk(32'(rx_out), 32'h0);
      csw_bus_model_inst.drive(1'b0);
      wr(`CSW_OFS_CTRL, 32'h7);
      wait_pins();
      chk(32'(bus_dom), 32'h1);
      @(posedge clock_in);
      tx_data_in <= 1'b1;
      wait_pins();
      chk(32'(bus_dom), 32'h0);
      wr(`CSW_OFS_IRQ_MASK, 32'h1);
      csw_bus_model_inst.pulse(0);
      wait_pins();
      chk(32'(irq_n), 32'h0);
      chk(32'(rx_out), 32'h1);
   endtask

   // A write while the clock enable is low must leave no trace.
   task automatic s_clock_enable();
      @(posedge clock_in);
      ce_in <= 1'b0;
      wr(`CSW_OFS_CTRL, 32'h0);
      @(posedge clock_in);
      ce_in <= 1'b1;
      rchk(`CSW_OFS_CTRL, 32'h7);
      chk(32'(det_en), 32'h1);
   endtask

   initial
   begin
      clock_in = 1'b0;
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      tx_data_in = 1'b1;
      do_reset();
      s_reset_values();
      s_mode_table();
      s_cfg_error();
      s_stop();
      s_sleep_map();
      s_auto_rearm();
      s_pins();
      s_clock_enable();
      summarize();
   end
endmodule
